// >>> logic/ddc_cfg_pkg.sv
package ddc_cfg_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [11:0] mode_and_decimation_idx = 12'h310;
    localparam logic [11:0] input_routing_idx       = 12'h311;
    localparam logic [13:0] mode_and_decimation_addr = 14'h0c40;
    localparam logic [13:0] input_routing_addr       = 14'h0c44;

    localparam logic [7:0] mode_and_decimation_rst = 8'h00;
    localparam logic [7:0] input_routing_rst       = 8'h00;

    // Field positions
    localparam int if_mode_lsb     = 4;
    localparam int c2r_bit         = 3;
    localparam int dec_lsb         = 0;
    localparam int ext_dec_lsb     = 4;
    localparam int q_sel_bit       = 2;
    localparam int i_sel_bit       = 0;
    localparam logic [7:0] routing_wmask = 8'hf5;

    localparam logic [2:0] dec_extended = 3'h7;

    // AXI responses
    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    localparam int sample_w = 16;

    typedef enum logic [1:0] {
        if_variable,
        if_zero,
        if_quarter,
        if_test
    } if_mode_t;

    // Stage enable mask bits
    localparam int st_hb1 = 0;
    localparam int st_hb2 = 1;
    localparam int st_hb3 = 2;
    localparam int st_hb4 = 3;
    localparam int st_tb1 = 4;
    localparam int st_tb2 = 5;
    localparam int st_fb  = 6;

endpackage

// >>> logic/decim_counter.sv
`timescale 1ns/1ps
module decim_counter (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       in_valid,
    input  wire logic [5:0] ratio,
    output logic            out_strobe
);
    typedef struct packed {
        logic [5:0] cnt;
        logic       strobe;
    } cnt_state_t;

    cnt_state_t s_q;
    cnt_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.strobe = 1'b0;
        if (in_valid) begin
            // Ratio change mid-count is absorbed at the next wrap
            if (s_q.cnt + 6'h01 >= ratio) begin
                s_d.cnt = 6'h00;
                s_d.strobe = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign out_strobe = s_q.strobe;
endmodule

// >>> logic/ddc_decimation_config.sv
// Contract
// - Mode bits [5:4]: 00 variable, 01 zero, 10 quarter rate, 11 test
// - Complex-to-real clear: I and Q both valid as a pair
// - Complex-to-real set: I only, extra quarter-rate mixing
// - Code 000: halfband one+two, ratio 2 real or 4 complex
// - Code 001: halfband one..three, ratio 4 real or 8 complex
// - Code 010: all four halfbands, ratio 8 real or 16 complex
// - Code 011: halfband one only, ratio 1 real or 2 complex
// - Code 100: halfband one plus thirdband two, ratio 3 or 6
// - Code 101: halfband one, two plus thirdband two, ratio 6 or 12
// - Code 110: halfband one..three plus thirdband two, ratio 12 or 24
// - Code 111: chain chosen by extended four-bit field
// - Extended field ignored unless primary code is all ones
// - Extended 0: thirdband two plus four halfbands, ratio 48 or 24
// - Extended 2: fifthband plus halfband one, ratio 10 or 5
// - Extended 3: fifthband plus halfbands one, two, ratio 20 or 10
// - Extended 4: fifthband plus halfbands one..three, ratio 40 or 20
// - Extended 7: thirdband one only, ratio 3, no half variant
// - Extended 8: fifthband plus thirdband one, ratio 15
// - Extended 9: halfband two, fifthband, thirdband one, ratio 30
// - Routing bit 2: Q from channel A when 0, B when 1
// - Routing bit 0: I from A or B; bits 1, 3 read-only zero
`timescale 1ns/1ps
module ddc_decimation_config (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [13:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [13:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [15:0] chan_a_data,
    input  wire logic [15:0] chan_b_data,
    input  wire logic        sample_valid,
    output logic [15:0]      out_i,
    output logic [15:0]      out_q,
    output logic             out_valid,
    output logic             out_q_valid,
    output logic             out_real,
    output logic [1:0]       if_mode,
    output logic [6:0]       stage_enable,
    output logic [5:0]       decim_ratio
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic        aw_held;
        logic [13:0] aw_addr;
        logic        w_held;
        logic [7:0]  w_data;
        logic        w_strb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  ctrl;
        logic [7:0]  route;
        logic [6:0]  stages;
        logic [5:0]  ratio;
        logic [1:0]  qphase;
        logic [15:0] i_smp;
        logic [15:0] q_smp;
        logic        ovalid;
        logic        qvalid;
        logic        oreal;
        logic [15:0] i_hold;
        logic [15:0] q_hold;
        logic        awrdy;
        logic        wrdy;
        logic        arrdy;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic   dec_strobe;

    ////////////////////////////////////////////////////////////////////////
    // Chain lookup: stage mask and ratio for the real or complex output chosen by c2r
    logic [6:0] sel_stages;
    logic [5:0] sel_ratio;
    logic       sel_ok;
    logic       c2r;

    always_comb begin
        sel_stages = s_q.stages;
        sel_ratio  = s_q.ratio;
        sel_ok     = 1'b1;
        c2r        = s_q.ctrl[ddc_cfg_pkg::c2r_bit];
        case (s_q.ctrl[2:0])
            3'h0: begin
                sel_stages = 7'h03;
                sel_ratio  = c2r ? 6'h02 : 6'h04;
            end
            3'h1: begin
                sel_stages = 7'h07;
                sel_ratio  = c2r ? 6'h04 : 6'h08;
            end
            3'h2: begin
                sel_stages = 7'h0f;
                sel_ratio  = c2r ? 6'h08 : 6'h10;
            end
            3'h3: begin
                sel_stages = 7'h01;
                sel_ratio  = c2r ? 6'h01 : 6'h02;
            end
            3'h4: begin
                sel_stages = 7'h21;
                sel_ratio  = c2r ? 6'h03 : 6'h06;
            end
            3'h5: begin
                sel_stages = 7'h23;
                sel_ratio  = c2r ? 6'h06 : 6'h0c;
            end
            3'h6: begin
                sel_stages = 7'h27;
                sel_ratio  = c2r ? 6'h0c : 6'h18;
            end
            default: begin
                // Extended field only consulted here
                case (s_q.route[7:4])
                    4'h0: begin
                        sel_stages = 7'h2f;
                        sel_ratio  = c2r ? 6'h18 : 6'h30;
                    end
                    4'h2: begin
                        sel_stages = 7'h41;
                        sel_ratio  = c2r ? 6'h05 : 6'h0a;
                    end
                    4'h3: begin
                        sel_stages = 7'h43;
                        sel_ratio  = c2r ? 6'h0a : 6'h14;
                    end
                    4'h4: begin
                        sel_stages = 7'h47;
                        sel_ratio  = c2r ? 6'h14 : 6'h28;
                    end
                    4'h7: begin
                        sel_stages = 7'h10;
                        sel_ratio  = 6'h03;
                    end
                    4'h8: begin
                        sel_stages = 7'h50;
                        sel_ratio  = 6'h0f;
                    end
                    4'h9: begin
                        sel_stages = 7'h52;
                        sel_ratio  = 6'h1e;
                    end
                    default: begin
                        sel_ok = 1'b0;
                    end
                endcase
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Input routing and quarter-rate mixing
    logic [15:0] i_in;
    logic [15:0] q_in;
    logic [15:0] i_mix;

    always_comb begin
        i_in = s_q.route[ddc_cfg_pkg::i_sel_bit] ? chan_b_data : chan_a_data;
        q_in = s_q.route[ddc_cfg_pkg::q_sel_bit] ? chan_b_data : chan_a_data;
        // Quarter-rate mixer as +I, +Q, -I, -Q sequence
        case (s_q.qphase)
            2'h0: i_mix = i_in;
            2'h1: i_mix = q_in;
            2'h2: i_mix = 16'h0000 - i_in;
            default: i_mix = 16'h0000 - q_in;
        endcase
    end

    decim_counter u_decim (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .in_valid   (sample_valid),
        .ratio      (s_q.ratio),
        .out_strobe (dec_strobe)
    );

    ////////////////////////////////////////////////////////////////////////
    logic        wr_go;
    logic        rd_go;
    logic [13:0] ra;

    always_comb begin
        s_d = s_q;
        ra  = s_axi_araddr;
        if (s_axi_awvalid && !s_q.aw_held) begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_held) begin
            s_d.w_held  = 1'b1;
            s_d.w_data  = s_axi_wdata[7:0];
            s_d.w_strb0 = s_axi_wstrb[0];
        end
        wr_go = s_q.aw_held && s_q.w_held && !s_q.bvalid;
        if (wr_go) begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = ddc_cfg_pkg::resp_okay;
            if (s_q.aw_addr[13:2] == ddc_cfg_pkg::mode_and_decimation_addr[13:2]) begin
                if (s_q.w_strb0) s_d.ctrl = s_q.w_data;
            end else if (s_q.aw_addr[13:2] == ddc_cfg_pkg::input_routing_addr[13:2]) begin
                if (s_q.w_strb0) s_d.route = s_q.w_data & ddc_cfg_pkg::routing_wmask;
            end else begin
                s_d.bresp = ddc_cfg_pkg::resp_slverr;
            end
        end
        if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;

        rd_go = s_axi_arvalid && !s_q.rvalid;
        if (rd_go) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = ddc_cfg_pkg::resp_okay;
            s_d.rdata  = 32'h00000000;
            if (ra[13:2] == ddc_cfg_pkg::mode_and_decimation_addr[13:2]) begin
                s_d.rdata = {24'h000000, s_q.ctrl};
            end else if (ra[13:2] == ddc_cfg_pkg::input_routing_addr[13:2]) begin
                s_d.rdata = {24'h000000, s_q.route};
            end else begin
                s_d.rresp = ddc_cfg_pkg::resp_slverr;
            end
        end
        if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;

        // Undefined extended code: keep last chain
        if (sel_ok) begin
            s_d.stages = sel_stages;
            s_d.ratio  = sel_ratio;
        end

        // Datapath
        if (sample_valid) begin
            s_d.qphase = s_q.qphase + 2'h1;
            // Held so a gap after the kept sample never leaks out
            s_d.i_hold = s_q.ctrl[ddc_cfg_pkg::c2r_bit] ? i_mix : i_in;
            s_d.q_hold = q_in;
        end
        s_d.ovalid = 1'b0;
        s_d.qvalid = 1'b0;
        s_d.oreal  = s_q.ctrl[ddc_cfg_pkg::c2r_bit];
        if (dec_strobe) begin
            s_d.ovalid = 1'b1;
            if (s_q.ctrl[ddc_cfg_pkg::c2r_bit]) begin
                s_d.i_smp = s_q.i_hold;
                s_d.q_smp = 16'h0000;
            end else begin
                s_d.i_smp  = s_q.i_hold;
                s_d.q_smp  = s_q.q_hold;
                s_d.qvalid = 1'b1;
            end
        end
        s_d.awrdy = !s_d.aw_held;
        s_d.wrdy  = !s_d.w_held;
        s_d.arrdy = !s_d.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q        <= '0;
            s_q.ctrl   <= ddc_cfg_pkg::mode_and_decimation_rst;
            s_q.route  <= ddc_cfg_pkg::input_routing_rst;
            s_q.stages <= 7'h03;
            s_q.ratio  <= 6'h04;
            s_q.awrdy  <= 1'b1;
            s_q.wrdy   <= 1'b1;
            s_q.arrdy  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address and data are taken independently and held until both have arrived
    assign s_axi_awready = s_q.awrdy;
    assign s_axi_wready  = s_q.wrdy;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = s_q.arrdy;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;
    assign out_i         = s_q.i_smp;
    assign out_q         = s_q.q_smp;
    assign out_valid     = s_q.ovalid;
    assign out_q_valid   = s_q.qvalid;
    assign out_real      = s_q.oreal;
    assign if_mode       = s_q.ctrl[5:4];
    assign stage_enable  = s_q.stages;
    assign decim_ratio   = s_q.ratio;
endmodule

// >>> bench/ddc_decimation_config_props.sv
`timescale 1ns/1ps
module ddc_decimation_config_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [13:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [15:0] out_q,
    input wire logic        out_valid,
    input wire logic        out_q_valid,
    input wire logic        out_real,
    input wire logic [1:0]  if_mode,
    input wire logic [6:0]  stage_enable,
    input wire logic [5:0]  decim_ratio
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Stage factors multiplied; real output halves unless thirdband one is enabled
    function automatic logic [5:0] exp_ratio(input logic [6:0] se, input logic rl);
        logic [7:0] p;
        p = 8'h01 << $countones(se[3:0]);
        if (se[4] || se[5]) p = p * 8'h03;
        if (se[6]) p = p * 8'h05;
        if (rl && !se[4]) p = p >> 1;
        return p[5:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    a_real_q_quiet: assert property (out_real |-> !out_q_valid)
        else $error("Q strobe in real mode");
    a_real_q_zero: assert property (out_valid && out_real |-> out_q == 16'h0000)
        else $error("Q data nonzero in real mode");
    a_cplx_pair: assert property (out_valid && !out_real |-> out_q_valid)
        else $error("I without Q in complex mode");
    a_q_with_i: assert property (out_q_valid |-> out_valid)
        else $error("Q strobe without I");
    // Stability guard skips the cycle where stage_enable, out_real and decim_ratio change; all three update together
    a_ratio_stages: assert property ($stable(stage_enable) && $stable(out_real)
        && $stable(decim_ratio) |-> decim_ratio == exp_ratio(stage_enable, out_real))
        else $error("Ratio does not match stages");
    a_mode_follows: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && s_axi_wstrb[0]
        && s_axi_awaddr == ddc_cfg_pkg::mode_and_decimation_addr
        |-> ##2 (if_mode == $past(s_axi_wdata[5:4], 2))
        ##1 (out_real == $past(s_axi_wdata[3], 3)))
        else $error("Mode outputs not updated");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("Write response late");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("Read data dropped");
    a_reset_state: assert property ($rose(aresetn) |-> stage_enable == 7'h03
        && decim_ratio == 6'h04 && !out_valid)
        else $error("Bad state after reset");
endmodule

bind ddc_decimation_config ddc_decimation_config_props i_props (.*);

// >>> bench/conv_core_model.sv
`timescale 1ns/1ps
module conv_core_model (
    input wire logic  aclk,
    output logic [15:0] chan_a_data,
    output logic [15:0] chan_b_data,
    output logic        sample_valid
);
    initial begin
        sample_valid = 1'b0;
        chan_a_data = 16'h0000;
        chan_b_data = 16'hffff;
    end

    // Gaps show inverted data so stale words never pass as samples
    task automatic burst(input int n, input bit slow, input logic [15:0] a, input logic [15:0] b);
        for (int k = 0; k < n; k++) begin
            @(posedge aclk);
            sample_valid <= 1'b1;
            chan_a_data <= a;
            chan_b_data <= b;
            if (slow) repeat ($urandom_range(2)) begin
                @(posedge aclk);
                sample_valid <= 1'b0;
                chan_a_data <= ~a;
                chan_b_data <= ~b;
            end
        end
        @(posedge aclk);
        sample_valid <= 1'b0;
        chan_a_data <= ~a;
        chan_b_data <= ~b;
    endtask
endmodule

// >>> bench/ddc_decimation_config_tb.sv
`timescale 1ns/1ps
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (x)); end end
module ddc_decimation_config_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [13:0] s_axi_awaddr = 14'h0000;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [13:0] s_axi_araddr = 14'h0000;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, if_mode;
    logic [31:0] s_axi_rdata;
    logic [15:0] chan_a_data, chan_b_data, out_i, out_q, a, b;
    logic        sample_valid, out_valid, out_q_valid, out_real;
    logic [6:0]  stage_enable;
    logic [5:0]  decim_ratio, r;
    logic [31:0] exp_iq;
    logic [33:0] q[$];
    logic [33:0] e;
    logic [31:0] sq[$];
    logic [31:0] x;
    logic [15:0] xi;
    int          miscompares = 0, checked = 0, cnt = 0;
    localparam logic [13:0] ma = ddc_cfg_pkg::mode_and_decimation_addr;
    localparam logic [13:0] ra = ddc_cfg_pkg::input_routing_addr;
    localparam logic [1:0]  ok = ddc_cfg_pkg::resp_okay;
    logic [5:0]  rt [14] = '{6'h04, 6'h08, 6'h10, 6'h02, 6'h06, 6'h0c, 6'h18,
                             6'h30, 6'h0a, 6'h14, 6'h28, 6'h03, 6'h0f, 6'h1e};
    logic [6:0]  st [14] = '{7'h03, 7'h07, 7'h0f, 7'h01, 7'h21, 7'h23, 7'h27,
                             7'h2f, 7'h41, 7'h43, 7'h47, 7'h10, 7'h50, 7'h52};
    logic [3:0]  ex [7] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9};

    always #25 aclk = ~aclk;
    ddc_decimation_config i_ddc_decimation_config (.*);
    conv_core_model i_src (.aclk(aclk), .chan_a_data(chan_a_data),
        .chan_b_data(chan_b_data), .sample_valid(sample_valid));

    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [13:0] ad, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] rs);
        logic aw, w;
        q.push_back({rs, 32'h0});
        aw = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                aw = 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                w = 1'b1;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(negedge aclk);
    endtask

    task automatic rd(input logic [13:0] ad, input logic [31:0] x, input logic [1:0] rs);
        q.push_back({rs, x});
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    task automatic test_done;
        if (miscompares == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
            e = q.pop_front();
            `CHK(s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0}, e)
        end
        if (out_valid) begin
            cnt++;
            if (sq.size() > 0) begin
                x = sq.pop_front();
                `CHK({out_i, out_q}, x)
            end
        end
    end

    initial begin
        repeat (40000) @(posedge aclk);
        miscompares++;
        test_done;
    end

    initial begin
        void'($urandom(32'h18c4));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ma, 32'h0, ok);
        rd(ra, 32'h0, ok);
        for (int m = 0; m < 4; m++) begin
            wr(ma, {26'h0, m[1:0], 4'h0}, 4'h1, ok);
            `CHK(if_mode, m[1:0])
            rd(ma, {26'h0, m[1:0], 4'h0}, ok);
        end
        wr(ra, 32'hff, 4'h1, ok);
        rd(ra, 32'hf5, ok);
        wr(ra, 32'h0, 4'h0, ok);
        rd(ra, 32'hf5, ok);
        wr(14'h0c48, 32'h1, 4'h1, ddc_cfg_pkg::resp_slverr);
        rd(14'h0c48, 32'h0, ddc_cfg_pkg::resp_slverr);
        // Complex ratio 2 with fixed channel words exposes the routing
        for (int s = 0; s < 4; s++) begin
            a = 16'($urandom);
            b = 16'($urandom);
            wr(ra, {29'h0, s[1], 1'b0, s[0]}, 4'h1, ok);
            wr(ma, 32'h3, 4'h1, ok);
            exp_iq = {s[0] ? b : a, s[1] ? b : a};
            repeat (8) sq.push_back(exp_iq);
            i_src.burst(16, s[0], a, b);
            repeat (4) @(negedge aclk);
            `CHK(sq.size(), 0)
        end
        // Sixty-four samples so far, so the mixer phase is back at zero
        a = 16'($urandom);
        b = 16'($urandom);
        wr(ra, 32'h4, 4'h1, ok);
        wr(ma, 32'hb, 4'h1, ok);
        for (int j = 0; j < 8; j++) begin
            xi = j[0] ? b : a;
            if (j[1]) xi = 16'h0000 - xi;
            sq.push_back({xi, 16'h0000});
        end
        i_src.burst(8, 1'b1, a, b);
        repeat (4) @(negedge aclk);
        `CHK(sq.size(), 0)
        for (int k = 0; k < 14; k++) begin
            for (int c = 0; c < 2; c++) begin
                r = (c == 1 && k < 11) ? rt[k] >> 1 : rt[k];
                // Same channel for I and Q, as the real mixer expects
                wr(ra, {24'h0, (k < 7) ? 4'($urandom_range(15)) : ex[k % 7], 4'h0},
                   4'h1, ok);
                wr(ma, {27'h0, c[0], (k < 7) ? k[2:0] : 3'h7}, 4'h1, ok);
                `CHK(stage_enable, st[k])
                `CHK(decim_ratio, r)
                // Priming lets any leftover count phase wrap out
                i_src.burst(64, 1'b0, 16'($urandom), 16'($urandom));
                repeat (4) @(negedge aclk);
                cnt = 0;
                i_src.burst(4 * r, k[0], 16'($urandom), 16'($urandom));
                repeat (4) @(negedge aclk);
                `CHK(cnt, 4)
            end
        end
        wr(ra, 32'h50, 4'h1, ok);
        `CHK(decim_ratio, 6'h1e)
        `CHK(stage_enable, 7'h52)
        test_done;
    end
endmodule
